/* File: rcps_checker.sv */
/*
  Port checker for rcps_top: reset pin, phases, vector, modes, clock.
  Assumes a bind into rcps_top; one clock, synchronous active-low nrst.
*/
`timescale 1ns/1ps
`default_nettype none

module rcps_checker #(
  parameter int TW_RSTL_OUT_CYC = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and sources
  input wire logic rst_pin_i,
  input wire logic rst_pin_oe,
  input wire logic wdg_underflow,
  input wire logic sw_reset,
  // Supply set-up
  input wire logic cable_present_flag,
  input wire logic plug_event_irq_enable,
  input wire logic usb_switch_opt_sel,
  // Clock and power outputs
  input wire logic osc_48m_sel,
  input wire logic pll_enable,
  input wire logic usb_clk_enable,
  input wire logic usb_if_enable,
  input wire logic xfer_cop_clk_en,
  input wire logic core_clk,
  input wire rcps_pkg::rcps_div_t core_div,
  input wire logic usb_switch_enable_n_oe,
  // Core side
  input wire logic core_rst_n,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_addr,
  input wire logic plug_irq,
  input wire logic usb_mode
);
  import rcps_pkg::*;
  // ************************************************************
  // Helper counters
  // ************************************************************
  int src_cnt_reg;
  logic clk_q_reg;
  logic [7:0] run_cnt_reg;
  logic src_hit;
  // Own drive on the pin is not an external request
  assign src_hit = wdg_underflow | sw_reset | (~rst_pin_i & ~rst_pin_oe);
  always_ff @(posedge clk) begin
    if (!nrst) src_cnt_reg <= TW_RSTL_OUT_CYC;
    else if (src_hit) src_cnt_reg <= 0;
    else if (src_cnt_reg < TW_RSTL_OUT_CYC) src_cnt_reg <= src_cnt_reg + 1;
  end
  // Samples since the last core clock edge
  always_ff @(posedge clk) begin
    clk_q_reg <= core_clk;
    if (core_clk != clk_q_reg) run_cnt_reg <= 8'h01;
    else if (run_cnt_reg != 8'hFF) run_cnt_reg <= run_cnt_reg + 8'h01;
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_src_oe;
    (wdg_underflow || sw_reset) |=> (rst_pin_oe && !core_rst_n);
  endproperty
  a_src_oe: assert property (p_src_oe) else $error("source missed");
  property p_ext;
    (!rst_pin_i && !rst_pin_oe) |-> ##[1:2] (rst_pin_oe && !core_rst_n);
  endproperty
  a_ext: assert property (p_ext) else $error("pin low missed");
  property p_stretch;
    (src_cnt_reg >= 2 && src_cnt_reg < TW_RSTL_OUT_CYC) |-> rst_pin_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("pulse short");
  property p_hold;
    !core_rst_n |-> rst_pin_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("pin released early");
  property p_fetch;
    $rose(vec_fetch) |-> vec_addr == 16'hFFFE ##1
      (vec_fetch && vec_addr == 16'hFFFF) ##1
      (!vec_fetch && core_rst_n && !rst_pin_oe);
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  property p_run;
    core_rst_n |-> (!vec_fetch && pll_enable == usb_mode &&
      osc_48m_sel == usb_mode);
  endproperty
  a_run: assert property (p_run) else $error("bad run mode");
  property p_sa;
    (core_rst_n && !usb_mode) |-> !(usb_clk_enable || usb_if_enable ||
      xfer_cop_clk_en);
  endproperty
  a_sa: assert property (p_sa) else $error("usb on standalone");
  property p_sw;
    core_rst_n |-> usb_switch_enable_n_oe == (usb_mode &&
      plug_event_irq_enable && usb_switch_opt_sel);
  endproperty
  a_sw: assert property (p_sw) else $error("switch wrong");
  property p_irq;
    (plug_event_irq_enable && $changed(cable_present_flag)) |=> plug_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("plug irq missed");
  property p_duty;
    (core_rst_n && core_clk != clk_q_reg) |-> run_cnt_reg == 8'(core_div);
  endproperty
  a_duty: assert property (p_duty) else $error("duty wrong");
endmodule
`default_nettype wire

/* File: rcps_clkdiv.sv */
/*
  Square-wave divider: toggles every half_div clocks, so duty stays 50%.
  Assumes half_div is at least 1; a new ratio takes effect at once, in the half period in progress.
*/
`timescale 1ns/1ps
`default_nettype none

module rcps_clkdiv
  import rcps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Ratio
  input wire rcps_pkg::rcps_div_t half_div,
  // Output wave and rising tick
  output logic clk_out,
  output logic rise
);
  rcps_div_t cnt_reg;
  logic clk_out_reg;
  logic rise_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= '0;
      clk_out_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (cnt_reg + rcps_div_t'(1) >= half_div) begin
      cnt_reg <= '0;
      clk_out_reg <= ~clk_out_reg;
      rise_reg <= ~clk_out_reg;
    end else begin
      cnt_reg <= cnt_reg + rcps_div_t'(1);
      rise_reg <= 1'b0;
    end
  end

  assign clk_out = clk_out_reg;
  assign rise = rise_reg;
endmodule

`default_nettype wire

/* File: rcps_far_model.sv */
/*
  Far side: board reset button on the open-drain pin, and the PLL.
  Assumes the pin has a pull-up and lock follows enable after a delay.
*/
`timescale 1ns/1ps
`default_nettype none

module rcps_far_model #(
  parameter int LOCK_CYC = 300
) (
  // Clock
  input wire logic clk,
  // Board and design drive
  input wire logic ext_pull,
  input wire logic rst_pin_oe,
  input wire logic pll_enable,
  // Toward the design
  output logic rst_pin_i,
  output logic pll_lock
);
  int lock_cnt;
  // Pull-up wins unless some party pulls low
  assign rst_pin_i = ~(ext_pull | rst_pin_oe);
  // Lock drops at once when the PLL is switched off
  always_ff @(posedge clk) begin
    if (!pll_enable) lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYC) lock_cnt <= lock_cnt + 1;
  end
  assign pll_lock = pll_enable && (lock_cnt == LOCK_CYC);
endmodule
`default_nettype wire

/* File: rcps_pkg.sv */
/*
  Types of the reset, clock and power sequencer.
  Assumes rcps_regs.svh is on the include path.
*/
`include "rcps_regs.svh"

package rcps_pkg;
  typedef enum logic [3:0] {
    RCPS_ACTIVE = 4'b0001,
    RCPS_DELAY = 4'b0010,
    RCPS_FETCH = 4'b0100,
    RCPS_RUN = 4'b1000
  } rcps_phase_e;

  typedef logic [1:0] rcps_prescale_t;
  typedef logic [`RCPS_DIV_W-1:0] rcps_div_t;
endpackage

/* File: rcps_regs.svh */
/*
  Constants of the reset, clock and power sequencer: timing figures,
  phase lengths, vector address and divider ratios.
  Assumes a 50 MHz system clock and inclusion by bare name.
*/
`ifndef RCPS_REGS_SVH
`define RCPS_REGS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define RCPS_CLK_PERIOD_NS 20
`define RCPS_TW_RSTL_OUT_NS 20000
`define RCPS_TW_RSTL_OUT_CYC \
  ((`RCPS_TW_RSTL_OUT_NS + `RCPS_CLK_PERIOD_NS - 1) / `RCPS_CLK_PERIOD_NS)

// ************************************************************
// Reset phases
// ************************************************************
`define RCPS_DELAY_SA_CYC 512
`define RCPS_DELAY_USB_CYC 256
`define RCPS_FETCH_CYC 2
`define RCPS_VECTOR_ADDR 16'hFFFE

// ************************************************************
// Oscillator and core clock ratios
// ************************************************************
`define RCPS_OSC_SA_MHZ 12
`define RCPS_OSC_USB_MHZ 48
`define RCPS_CORE_MAX_SA_MHZ 6
`define RCPS_CORE_MAX_USB_MHZ 8
`define RCPS_XFER_COP_MHZ 24
`define RCPS_DIV_W 5

`endif

/* File: rcps_stretch.sv */
/*
  Pulse stretcher: holds busy for CYCLES clocks after the last trigger.
  Assumes a synchronous trigger on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rcps_stretch #(
  parameter int CYCLES = 1000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Trigger and result
  input wire logic trig,
  output logic busy
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  logic [W-1:0] cnt_reg;

  // Retrigger restarts the full width
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (trig) begin
      cnt_reg <= LOAD;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

`default_nettype wire

/* File: rcps_top.sv */
/*
  Reset sequencer with clock and supply mode selection.
  Assumes all inputs synchronous to clk; the core clock is modelled as a
  divided wave of clk whose ratio follows the oscillator-relative divisor.
*/
`include "rcps_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rcps_top #(
  parameter bit HAS_UV_MONITOR = 1'b0,
  parameter int TW_RSTL_OUT_CYC = `RCPS_TW_RSTL_OUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Open-drain reset pin
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // Reset sources
  input wire logic uv_low,
  input wire logic wdg_underflow,
  input wire logic sw_reset,
  // Supply and option inputs
  input wire logic cable_present_flag,
  input wire logic plug_event_irq_enable,
  input wire logic usb_switch_opt_sel,
  input wire logic pll_lock,
  // Core clock control, misc_control_one bits
  input wire rcps_pkg::rcps_prescale_t cpu_clock_prescale,
  input wire logic prescale_select_enable,
  // Clock and power outputs
  output logic osc_48m_sel,
  output logic pll_enable,
  output logic usb_clk_enable,
  output logic usb_if_enable,
  output logic xfer_cop_clk_en,
  output logic core_clk,
  output var rcps_pkg::rcps_div_t core_div,
  // Supply switch pin, active low
  output logic usb_switch_enable_n_o,
  output logic usb_switch_enable_n_oe,
  // Core side
  output logic core_rst_n,
  output logic vec_fetch,
  output logic [15:0] vec_addr,
  output logic plug_irq,
  output logic usb_mode
);
  import rcps_pkg::*;

  // ************************************************************
  // Divider selection
  // ************************************************************
  // Returns the oscillator-to-core divisor. The table never goes below
  // the ratio that gives the mode ceiling, so software cannot overclock.
  function automatic rcps_div_t core_divisor(input logic usb,
                                             input logic en,
                                             input rcps_prescale_t cp);
    rcps_div_t d;
    d = '0;
    if (usb) begin
      unique case ({en, cp})
        3'b100: d = rcps_div_t'(`RCPS_OSC_USB_MHZ / `RCPS_CORE_MAX_USB_MHZ);
        3'b101: d = rcps_div_t'(`RCPS_OSC_USB_MHZ / 6);
        3'b110: d = rcps_div_t'(`RCPS_OSC_USB_MHZ / 4);
        3'b111: d = rcps_div_t'(`RCPS_OSC_USB_MHZ / 2);
        default: d = rcps_div_t'(`RCPS_OSC_USB_MHZ / 6);
      endcase
    end else begin
      unique case ({en, cp})
        3'b100: d = rcps_div_t'(`RCPS_OSC_SA_MHZ / `RCPS_CORE_MAX_SA_MHZ);
        3'b101: d = rcps_div_t'(`RCPS_OSC_SA_MHZ / 3);
        3'b110: d = rcps_div_t'(`RCPS_OSC_SA_MHZ / 2);
        3'b111: d = rcps_div_t'(`RCPS_OSC_SA_MHZ / 1);
        default: d = rcps_div_t'(`RCPS_OSC_SA_MHZ / 3);
      endcase
    end
    return d;
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam logic [9:0] DELAY_SA = 10'(`RCPS_DELAY_SA_CYC);
  localparam logic [9:0] DELAY_USB = 10'(`RCPS_DELAY_USB_CYC);
  localparam logic [1:0] FETCH_LAST = 2'(`RCPS_FETCH_CYC - 1);
  localparam logic [15:0] VEC_BASE = `RCPS_VECTOR_ADDR;

  rcps_phase_e phase_reg;
  rcps_phase_e phase_next;
  logic [9:0] delay_cnt_reg;
  logic [1:0] fetch_cnt_reg;
  logic lock_seen_reg;
  logic pin_low_seen_reg;
  logic pin_ext_low;
  logic ext_trig;
  logic ext_busy;
  logic wdg_busy;
  logic src_active;
  logic dual_supply;
  logic usb_mode_reg;
  logic usb_mode_next;
  logic pin_oe_reg;
  logic core_rst_n_reg;
  logic vec_fetch_reg;
  logic [15:0] vec_addr_reg;
  logic cable_reg;
  logic plug_irq_reg;
  logic osc_sel_reg;
  logic pll_en_reg;
  logic usb_en_reg;
  logic xfer_en_reg;
  logic sw_oe_reg;
  rcps_div_t core_div_reg;
  rcps_div_t half_div;
  logic core_clk_w;
  logic core_rise;
  logic delay_done;

  // ************************************************************
  // Reset sources
  // ************************************************************
  // Own drive masked, else the pin would hold its own reset forever
  assign pin_ext_low = !rst_pin_i && !pin_oe_reg;
  // Pin recognised on its falling sample; a short pulse is stretched
  assign ext_trig = pin_ext_low && !pin_low_seen_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_low_seen_reg <= 1'b0;
    end else begin
      pin_low_seen_reg <= pin_ext_low;
    end
  end

  rcps_stretch #(.CYCLES(TW_RSTL_OUT_CYC)) u_ext_stretch (
    .clk(clk),
    .nrst(nrst),
    .trig(ext_trig),
    .busy(ext_busy)
  );

  rcps_stretch #(.CYCLES(TW_RSTL_OUT_CYC)) u_wdg_stretch (
    .clk(clk),
    .nrst(nrst),
    .trig(wdg_underflow | sw_reset),
    .busy(wdg_busy)
  );

  // A pin still low when our drive ends re-enters the active phase
  assign src_active = ext_trig || pin_ext_low || ext_busy
                      || wdg_busy || wdg_underflow || sw_reset
                      || (HAS_UV_MONITOR && uv_low);

  // ************************************************************
  // Supply mode
  // ************************************************************
  // Monitor variants stay in reset below threshold, so no dual mode
  assign dual_supply = !HAS_UV_MONITOR && plug_event_irq_enable
                       && usb_switch_opt_sel;

  // Mode is taken only while in reset, so a plug or unplug takes effect
  // after the software reset that software issues on the interrupt
  always_comb begin
    usb_mode_next = usb_mode_reg;
    if (phase_reg == RCPS_ACTIVE) begin
      usb_mode_next = dual_supply ? cable_present_flag : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      usb_mode_reg <= 1'b1;
    end else begin
      usb_mode_reg <= usb_mode_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_sel_reg <= 1'b0;
      pll_en_reg <= 1'b0;
      usb_en_reg <= 1'b0;
      xfer_en_reg <= 1'b0;
    end else begin
      osc_sel_reg <= usb_mode_reg;
      pll_en_reg <= usb_mode_reg;
      usb_en_reg <= usb_mode_reg && pll_lock;
      xfer_en_reg <= usb_mode_reg && pll_lock;
    end
  end

  // Switch driven low only in dual USB mode, else floating
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sw_oe_reg <= 1'b0;
    end else begin
      sw_oe_reg <= dual_supply && usb_mode_next;
    end
  end

  // ************************************************************
  // Core clock
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_div_reg <= rcps_div_t'(`RCPS_OSC_SA_MHZ / 3);
    end else begin
      core_div_reg <= core_divisor(usb_mode_reg,
                                   prescale_select_enable,
                                   cpu_clock_prescale);
    end
  end

  // Half period in clk cycles scales with the oscillator divisor
  assign half_div = (core_div_reg == '0) ? rcps_div_t'(1) : core_div_reg;

  rcps_clkdiv u_core_div (
    .clk(clk),
    .nrst(nrst),
    .half_div(half_div),
    .clk_out(core_clk_w),
    .rise(core_rise)
  );

  // ************************************************************
  // Reset phase sequencer
  // ************************************************************
  assign delay_done = usb_mode_reg
                      ? (delay_cnt_reg == DELAY_USB - 10'd1)
                      : (delay_cnt_reg == DELAY_SA - 10'd1);

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      RCPS_ACTIVE: begin
        if (!src_active) begin
          phase_next = RCPS_DELAY;
        end
      end
      RCPS_DELAY: begin
        if (src_active) begin
          phase_next = RCPS_ACTIVE;
        end else if (delay_done && core_rise
                     && (lock_seen_reg || !usb_mode_reg)) begin
          phase_next = RCPS_FETCH;
        end
      end
      RCPS_FETCH: begin
        if (src_active) begin
          phase_next = RCPS_ACTIVE;
        end else if (fetch_cnt_reg == FETCH_LAST) begin
          phase_next = RCPS_RUN;
        end
      end
      RCPS_RUN: begin
        if (src_active) begin
          phase_next = RCPS_ACTIVE;
        end
      end
      default: phase_next = RCPS_ACTIVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_reg <= RCPS_ACTIVE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // USB delay waits for lock before counting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_seen_reg <= 1'b0;
    end else if (phase_reg != RCPS_DELAY) begin
      lock_seen_reg <= 1'b0;
    end else if (pll_lock) begin
      lock_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      delay_cnt_reg <= '0;
    end else if (phase_reg != RCPS_DELAY) begin
      delay_cnt_reg <= '0;
    end else if (core_rise && (lock_seen_reg || !usb_mode_reg)
                 && !delay_done) begin
      delay_cnt_reg <= delay_cnt_reg + 10'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fetch_cnt_reg <= '0;
    end else if (phase_reg != RCPS_FETCH) begin
      fetch_cnt_reg <= '0;
    end else begin
      fetch_cnt_reg <= fetch_cnt_reg + 2'd1;
    end
  end

  // ************************************************************
  // Pin, core reset and vector
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_oe_reg <= 1'b1;
    end else begin
      // Held through fetch too, so the pin rises with the core reset
      pin_oe_reg <= (phase_next != RCPS_RUN);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_rst_n_reg <= 1'b0;
    end else begin
      core_rst_n_reg <= (phase_next == RCPS_RUN);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vec_fetch_reg <= 1'b0;
      vec_addr_reg <= VEC_BASE;
    end else begin
      vec_fetch_reg <= (phase_next == RCPS_FETCH);
      vec_addr_reg <= (phase_next == RCPS_FETCH && phase_reg == RCPS_FETCH)
                      ? VEC_BASE + 16'd1 : VEC_BASE;
    end
  end

  // ************************************************************
  // Plug event
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cable_reg <= 1'b0;
      plug_irq_reg <= 1'b0;
    end else begin
      cable_reg <= cable_present_flag;
      plug_irq_reg <= plug_event_irq_enable
                      && (cable_reg != cable_present_flag);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = pin_oe_reg;
  assign osc_48m_sel = osc_sel_reg;
  assign pll_enable = pll_en_reg;
  assign usb_clk_enable = usb_en_reg;
  assign usb_if_enable = usb_en_reg;
  assign xfer_cop_clk_en = xfer_en_reg;
  assign core_clk = core_clk_w;
  assign core_div = core_div_reg;
  assign usb_switch_enable_n_o = 1'b0;
  assign usb_switch_enable_n_oe = sw_oe_reg;
  assign core_rst_n = core_rst_n_reg;
  assign vec_fetch = vec_fetch_reg;
  assign vec_addr = vec_addr_reg;
  assign plug_irq = plug_irq_reg;
  assign usb_mode = usb_mode_reg;
endmodule

`default_nettype wire

/* File: testbench.sv */
/*
  Bench for rcps_top: table of supply and clock set-ups, then sources.
  Assumes design, checker and far-side model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rcps_pkg::*;
  localparam int TW = 8;
  localparam int LOCK = 300;
  logic clk = 1'b0;
  logic nrst, rst_pin_i, rst_pin_oe, uv_low, wdg_underflow, sw_reset;
  logic cable_present_flag, plug_event_irq_enable, usb_switch_opt_sel;
  logic pll_lock, prescale_select_enable, osc_48m_sel, pll_enable;
  logic usb_clk_enable, usb_if_enable, xfer_cop_clk_en, core_clk;
  logic usb_switch_enable_n_oe, core_rst_n, vec_fetch, plug_irq, usb_mode;
  logic ext_pull;
  logic [15:0] vec_addr, r;
  rcps_prescale_t cpu_clock_prescale;
  rcps_div_t core_div;
  int fail_count = 0;
  int n_tests = 0;
  int n, d, t, lk;
  // Row: enable 15, prescale 14:13, irq enable 12, option 11, cable 10,
  // usb mode 9, switch drive 8, divisor 4:0
  logic [15:0] rows [10] = '{16'h8206, 16'hAE08, 16'h0208, 16'hDF0C,
    16'hFF18, 16'h1804, 16'hB804, 16'hD806, 16'hF80C, 16'h9802};

  always #10 clk = ~clk;

  rcps_top #(.HAS_UV_MONITOR(1'b0), .TW_RSTL_OUT_CYC(TW)) u_dut (
    .clk(clk), .nrst(nrst), .rst_pin_i(rst_pin_i), .rst_pin_o(),
    .rst_pin_oe(rst_pin_oe), .uv_low(uv_low), .sw_reset(sw_reset),
    .wdg_underflow(wdg_underflow), .cable_present_flag(cable_present_flag),
    .plug_event_irq_enable(plug_event_irq_enable), .pll_lock(pll_lock),
    .usb_switch_opt_sel(usb_switch_opt_sel), .pll_enable(pll_enable),
    .cpu_clock_prescale(cpu_clock_prescale), .osc_48m_sel(osc_48m_sel),
    .prescale_select_enable(prescale_select_enable), .core_clk(core_clk),
    .usb_clk_enable(usb_clk_enable), .usb_if_enable(usb_if_enable),
    .xfer_cop_clk_en(xfer_cop_clk_en), .core_div(core_div),
    .usb_switch_enable_n_o(), .usb_switch_enable_n_oe(usb_switch_enable_n_oe),
    .core_rst_n(core_rst_n), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .plug_irq(plug_irq), .usb_mode(usb_mode)
  );
  rcps_far_model #(.LOCK_CYC(LOCK)) u_far (
    .clk(clk), .ext_pull(ext_pull), .rst_pin_oe(rst_pin_oe),
    .pll_enable(pll_enable), .rst_pin_i(rst_pin_i), .pll_lock(pll_lock)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic pulse(input logic [1:0] src);
    {wdg_underflow, sw_reset} = src;
    cyc(1);
    {wdg_underflow, sw_reset} = 2'b00;
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    cyc(8);
    chk({rst_pin_oe, core_rst_n, vec_fetch, plug_irq, pll_enable,
      usb_switch_enable_n_oe, usb_mode}, 7'b1000001);
    chk({vec_addr, 3'b000, core_div}, 24'hFFFE04);
    nrst = 1'b1;
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_fetch;
    n = 0;
    while (vec_fetch !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    chk(n < 20000, 1);
  endtask
  task automatic fetch_seq;
    chk(vec_addr, 16'hFFFE);
    cyc(1);
    chk({vec_fetch, vec_addr}, 17'h1FFFF);
    cyc(1);
    chk({vec_fetch, core_rst_n, rst_pin_oe}, 3'b010);
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    {nrst, uv_low, wdg_underflow, sw_reset, ext_pull} = 5'b00000;
    {cable_present_flag, plug_event_irq_enable, usb_switch_opt_sel} = 3'b0;
    {prescale_select_enable, cpu_clock_prescale} = 3'b000;
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      {prescale_select_enable, cpu_clock_prescale} = r[15:13];
      plug_event_irq_enable = r[12];
      usb_switch_opt_sel = r[11];
      cable_present_flag = r[10];
      do_reset();
      wait_fetch();
      d = 2 * int'(r[4:0]);
      t = r[9] ? 256 : 512;
      lk = r[9] ? LOCK : 0;
      chk(n >= (t - 1) * d + lk && n <= t * d + lk + 12, 1);
      fetch_seq();
      chk({usb_mode, pll_enable, osc_48m_sel, usb_if_enable, xfer_cop_clk_en,
        usb_switch_enable_n_oe}, {{5{r[9]}}, r[8]});
      chk(core_div, r[4:0]);
      cable_present_flag = !r[10];
      cyc(1);
      chk(plug_irq, r[12]);
      cable_present_flag = r[10];
      cyc(1);
      chk(plug_irq, r[12]);
      cyc(1);
      chk(plug_irq, 0);
    end
    // Watchdog then software source while running
    for (int k = 0; k < 2; k++) begin
      pulse(k ? 2'b01 : 2'b10);
      chk({rst_pin_oe, core_rst_n}, 2'b10);
      cyc(TW);
      chk(rst_pin_oe, 1);
      wait_fetch();
      fetch_seq();
    end
    // One-cycle press on the pin must be stretched
    ext_pull = 1'b1;
    cyc(1);
    ext_pull = 1'b0;
    cyc(2);
    chk({rst_pin_oe, core_rst_n}, 2'b10);
    cyc(TW);
    chk(rst_pin_i, 0);
    wait_fetch();
    fetch_seq();
    // Second source inside the delay restarts the count
    pulse(2'b10);
    cyc(200);
    pulse(2'b10);
    wait_fetch();
    chk(n >= 511 * d, 1);
    fetch_seq();
    // Plug-in, then software reset: switch drives low during and after
    cable_present_flag = 1'b1;
    cyc(1);
    chk({plug_irq, usb_switch_enable_n_oe}, 2'b10);
    pulse(2'b01);
    cyc(2);
    chk({rst_pin_oe, usb_switch_enable_n_oe}, 2'b11);
    wait_fetch();
    fetch_seq();
    chk({usb_mode, usb_switch_enable_n_oe, xfer_cop_clk_en}, 3'b111);
    // No monitor fitted, so a low-supply flag is not a source
    uv_low = 1'b1;
    cyc(20);
    chk(core_rst_n, 1);
    uv_low = 1'b0;
    report_and_stop();
  end

  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule

bind rcps_top rcps_checker #(.TW_RSTL_OUT_CYC(TW_RSTL_OUT_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .rst_pin_i(rst_pin_i), .rst_pin_oe(rst_pin_oe),
  .wdg_underflow(wdg_underflow), .sw_reset(sw_reset),
  .cable_present_flag(cable_present_flag), .pll_enable(pll_enable),
  .plug_event_irq_enable(plug_event_irq_enable), .core_clk(core_clk),
  .usb_switch_opt_sel(usb_switch_opt_sel), .osc_48m_sel(osc_48m_sel),
  .usb_clk_enable(usb_clk_enable), .usb_if_enable(usb_if_enable),
  .xfer_cop_clk_en(xfer_cop_clk_en), .core_div(core_div),
  .usb_switch_enable_n_oe(usb_switch_enable_n_oe), .core_rst_n(core_rst_n),
  .vec_fetch(vec_fetch), .vec_addr(vec_addr), .plug_irq(plug_irq),
  .usb_mode(usb_mode)
);
`default_nettype wire
